// ---- csp_pkg.sv ----
// Constants, types and carriers shared by the clock source, prescale and trim block
package csp_pkg;
    // Register addresses on the plain register port
    localparam logic [5:0] ADDR_PRESCALE = 6'h26;
    localparam logic [5:0] ADDR_TRIM = 6'h31;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // Prescale control register layout
    localparam int PS_SEL_W = 4;
    localparam int UNLOCK_BIT = 7;
    localparam logic [7:0] UNLOCK_WORD = 8'h80;
    localparam logic [2:0] UNLOCK_CYC = 3'h4;
    localparam logic [3:0] PS_RESET_DIV1 = 4'h0;
    localparam logic [3:0] PS_RESET_DIV8 = 4'h3;
    localparam logic [3:0] PS_MAX_CODE = 4'h8;
    localparam int PS_CNT_W = 8;

    // Trim register layout and the value held before the factory load
    localparam int TRIM_RANGE_BIT = 7;
    localparam logic [7:0] TRIM_RESET = 8'h00;

    // Source select codes
    localparam logic [2:0] BAND_0P4_0P9 = 3'h4;
    localparam logic [2:0] BAND_0P9_3P0 = 3'h5;
    localparam logic [2:0] BAND_3P0_8P0 = 3'h6;
    localparam logic [2:0] BAND_8P0_UP = 3'h7;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_RC8 = 4'h2;
    localparam logic [1:0] SUT_SHIPPED = 2'h2;

    // Timing: the clock runs at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int T_4MS_US = 4000;
    localparam int T_64MS_US = 64000;
    localparam int CYC_4MS = T_4MS_US * CLK_MHZ;
    localparam int CYC_64MS = T_64MS_US * CLK_MHZ;
    localparam int CYC_RST_BASE = 14;
    localparam int CYC_PD_258 = 258;
    localparam int CYC_PD_1K = 1024;
    localparam int CYC_PD_16K = 16384;
    localparam int CYC_PD_RC = 6;
    localparam int DLY_W = 24;

    typedef enum logic [2:0] {
        ST_LATCH = 3'b000,
        ST_RST_WAIT = 3'b001,
        ST_RUN = 3'b010,
        ST_PDOWN = 3'b011,
        ST_WAKE = 3'b100
    } csp_state_e;

    typedef struct packed {
        logic [3:0] clock_source_select_fuses;
        logic [1:0] startup_time_fuses;
        logic div8;
        logic clkout;
    } csp_fuse_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } csp_bus_s;
endpackage

// ---- csp_divider.sv ----
// Glitch-free power-of-two divider of the master clock
`timescale 1ns/1ns
module csp_divider #(
    parameter int SEL_W = 4,
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [SEL_W-1:0] sel,
    output logic tick,
    output logic clk_lvl
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [SEL_W-1:0] act_r;
    logic [SEL_W-1:0] act_nxt;
    logic tick_r;
    logic lvl_r;

    // Reserved codes divide as the largest legal factor
    wire [SEL_W-1:0] sel_eff = (sel > SEL_W'(csp_pkg::PS_MAX_CODE)) ? SEL_W'(csp_pkg::PS_MAX_CODE) : sel;
    wire boundary = (cnt_r == '0);
    wire [CNT_W:0] new_period = (CNT_W+1)'(1) << sel_eff;
    wire [CNT_W-1:0] new_top = CNT_W'(new_period - (CNT_W+1)'(1));
    // The factor only changes at a period end, so no short period is produced
    assign act_nxt = (run && boundary) ? sel_eff : act_r; // R09
    assign cnt_nxt = !run ? '0 : (boundary ? new_top : cnt_r - CNT_W'(1)); // R10
    wire [CNT_W:0] act_period = (CNT_W+1)'(1) << act_nxt;
    wire [CNT_W:0] act_half = act_period >> 1;
    wire lvl_nxt = run && ({1'b0, cnt_nxt} >= act_half);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            act_r <= '0;
            tick_r <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
            tick_r <= run && boundary; // R11
            lvl_r <= lvl_nxt;
        end
    end

    assign tick = tick_r;
    assign clk_lvl = lvl_r;
endmodule

// ---- csp_top.sv ----
// Clock source selection, start-up delay, system prescaler, clock output and RC trim
//
// Overview of operation
// (R01) Upper three source-select fuse bits pick the crystal band 100..111.
// (R02) Lowest band is for ceramic resonators only, never for quartz crystals.
// (R03) Low select bit 0 with start-up code 00 or 01 waits 258 cycles.
// (R04) Low bit 0 with 10/11, or low bit 1 with 00, waits 1024 cycles.
// (R05) Low bit 1 with start-up code 01, 10 or 11 waits 16384 cycles.
// (R06) After reset wait 14 cycles plus nothing, 4 ms or 64 ms per fuses.
// (R07) Shipped fuses: internal 8 MHz RC, start-up 10, divide by eight.
// (R08) Prescaler divides CPU, flash, I/O and ADC clocks for every source.
// (R09) Changing the factor makes no glitch and no period shorter than both.
// (R10) Prescaler is a counter on the master clock; its count is not readable.
// (R11) New factor takes effect after one old and one or two new periods.
// (R12) Clock-out fuse drives the system clock on its pin, unless oscillator pin.
// (R13) No clock on the clock output pin while reset is active.
// (R14) Clock output carries the divided system clock for non-crystal sources; with crystal sources the pin keeps its port function.
// (R15) Every reset loads the trim register with the factory calibration value.
// (R16) Trim register at 0x31 is read and write; writes retune the RC oscillator.
// (R17) Trim bit 7 selects low or high frequency range; the ranges overlap.
// (R18) Trim bits 6 to 0 tune monotonically from lowest to highest.
// (R19) Software keeps trim at or below 8.8 MHz while nonvolatile writes run.
// (R20) Software changes trim by at most 0x20 per calibration step.
// (R21) Unlock word first, new select within four cycles; unlock then clears.
// (R22) Select codes 0000 to 1000 divide by 1 to 256; higher codes reserved.
// (R23) Select resets to 0011 with divide-by-eight fuse, else to 0000.
// (R24) Fuses are sampled at reset and held constant during operation.
// (R25) Start-up delay counts oscillator cycles with the system clock gated off.
`timescale 1ns/1ns
module csp_top #(
    parameter int CYC_4MS_P = csp_pkg::CYC_4MS,
    parameter int CYC_64MS_P = csp_pkg::CYC_64MS,
    parameter int CYC_16K_P = csp_pkg::CYC_PD_16K
) (
    input wire logic clk,
    input wire logic nrst,
    input wire csp_pkg::csp_fuse_s fuses,
    input wire logic [7:0] factory_trim,
    input wire csp_pkg::csp_bus_s bus,
    input wire logic powerdown_req,
    input wire logic port_out,
    input wire logic port_oe,
    output logic [7:0] rdata,
    output logic sys_clk,
    output logic sys_tick,
    output logic core_run,
    output logic clock_out_pin_o,
    output logic clock_out_pin_oe,
    output logic xtal_mode,
    output logic [1:0] osc_band,
    output logic [7:0] trim_value
);
    csp_pkg::csp_state_e state_r;
    csp_pkg::csp_state_e state_nxt;
    csp_pkg::csp_fuse_s fuse_r;
    logic [csp_pkg::DLY_W-1:0] dly_r;
    logic [csp_pkg::DLY_W-1:0] dly_nxt;
    logic [7:0] trim_r;
    logic [7:0] trim_nxt;
    logic [3:0] ps_sel_r;
    logic [3:0] ps_sel_nxt;
    logic unlock_r;
    logic unlock_nxt;
    logic [2:0] unlock_cnt_r;
    logic [2:0] unlock_cnt_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic run_r;
    logic cko_r;
    logic cko_oe_r;
    logic xtal_r;
    logic [1:0] band_r;
    logic div_tick;
    logic div_lvl;

    // Delay figures at the counter's width
    localparam logic [csp_pkg::DLY_W-1:0] D_BASE = csp_pkg::DLY_W'(csp_pkg::CYC_RST_BASE);
    localparam logic [csp_pkg::DLY_W-1:0] D_4MS = csp_pkg::DLY_W'(csp_pkg::CYC_RST_BASE + CYC_4MS_P);
    localparam logic [csp_pkg::DLY_W-1:0] D_64MS = csp_pkg::DLY_W'(csp_pkg::CYC_RST_BASE + CYC_64MS_P);
    localparam logic [csp_pkg::DLY_W-1:0] D_258 = csp_pkg::DLY_W'(csp_pkg::CYC_PD_258);
    localparam logic [csp_pkg::DLY_W-1:0] D_1K = csp_pkg::DLY_W'(csp_pkg::CYC_PD_1K);
    localparam logic [csp_pkg::DLY_W-1:0] D_16K = csp_pkg::DLY_W'(CYC_16K_P);
    localparam logic [csp_pkg::DLY_W-1:0] D_RC = csp_pkg::DLY_W'(csp_pkg::CYC_PD_RC);

    // Source decoding from the held fuse copy
    wire [2:0] sel_hi = fuse_r.clock_source_select_fuses[3:1];
    wire sel_lo = fuse_r.clock_source_select_fuses[0];
    wire is_xtal = (sel_hi >= csp_pkg::BAND_0P4_0P9); // R01
    wire [1:0] band = sel_hi[1:0]; // R01

    // Power-down start-up length, crystal and resonator codes
    wire pd_258 = !sel_lo && !fuse_r.startup_time_fuses[1]; // R03
    wire pd_1k = (!sel_lo && fuse_r.startup_time_fuses[1]) || (sel_lo && (fuse_r.startup_time_fuses == 2'b00)); // R04
    wire [csp_pkg::DLY_W-1:0] pd_xtal = pd_258 ? D_258 : (pd_1k ? D_1K : D_16K); // R05
    wire [csp_pkg::DLY_W-1:0] pd_len = is_xtal ? pd_xtal : D_RC;

    // Additional reset delay for crystal codes, indexed by low bit and start-up code.
    // Taken from the live fuses, because the held copy is only caught at that same edge.
    logic [csp_pkg::DLY_W-1:0] rst_xtal;
    always_comb begin
        rst_xtal = D_BASE;
        case ({fuses.clock_source_select_fuses[0], fuses.startup_time_fuses})
            3'b000: rst_xtal = D_4MS;
            3'b001: rst_xtal = D_64MS;
            3'b010: rst_xtal = D_BASE;
            3'b011: rst_xtal = D_4MS;
            3'b100: rst_xtal = D_64MS;
            3'b101: rst_xtal = D_BASE;
            3'b110: rst_xtal = D_4MS;
            3'b111: rst_xtal = D_64MS;
            default: rst_xtal = D_BASE;
        endcase
    end

    // Internal oscillator codes follow their own start-up table; reserved 11 takes the longest
    logic [csp_pkg::DLY_W-1:0] rst_rc;
    always_comb begin
        rst_rc = D_64MS;
        case (fuses.startup_time_fuses)
            2'b00: rst_rc = D_BASE;
            2'b01: rst_rc = D_4MS;
            2'b10: rst_rc = D_64MS;
            default: rst_rc = D_64MS;
        endcase
    end

    wire lf_xtal = (fuses.clock_source_select_fuses[3:1] >= csp_pkg::BAND_0P4_0P9);
    wire [csp_pkg::DLY_W-1:0] rst_len = lf_xtal ? rst_xtal : rst_rc; // R06

    // Start-up sequencer: the core clock stays gated until the count ends
    wire dly_done = (dly_r == csp_pkg::DLY_W'(1));
    always_comb begin
        state_nxt = state_r;
        dly_nxt = dly_r;
        case (state_r)
            csp_pkg::ST_LATCH: begin
                state_nxt = csp_pkg::ST_RST_WAIT;
            end
            csp_pkg::ST_RST_WAIT: begin
                dly_nxt = dly_r - csp_pkg::DLY_W'(1); // R25
                if (dly_done) begin
                    state_nxt = csp_pkg::ST_RUN; // R06
                end
            end
            csp_pkg::ST_RUN: begin
                if (powerdown_req) begin
                    state_nxt = csp_pkg::ST_PDOWN;
                end
            end
            csp_pkg::ST_PDOWN: begin
                if (!powerdown_req) begin
                    state_nxt = csp_pkg::ST_WAKE;
                    dly_nxt = pd_len; // R03 R04 R05
                end
            end
            csp_pkg::ST_WAKE: begin
                dly_nxt = dly_r - csp_pkg::DLY_W'(1); // R25
                if (dly_done) begin
                    state_nxt = csp_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = csp_pkg::ST_LATCH;
            end
        endcase
    end

    // Latch cycle: first edge after release catches fuses, trim, select and reset delay
    wire latch_cyc = (state_r == csp_pkg::ST_LATCH);
    wire load_rst = latch_cyc;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= csp_pkg::ST_LATCH;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Fuses are caught once after reset release, then held
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fuse_r <= '{clock_source_select_fuses: csp_pkg::CLOCK_SOURCE_SELECT_FUSES_RC8, startup_time_fuses: csp_pkg::SUT_SHIPPED, div8: 1'b1, clkout: 1'b0}; // R07
        end else if (latch_cyc) begin
            fuse_r <= fuses; // R24
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dly_r <= '0;
        end else if (load_rst) begin
            dly_r <= rst_len; // R06
        end else begin
            dly_r <= dly_nxt;
        end
    end

    // Register decoding
    wire wr_ps = bus.wr && (bus.addr == csp_pkg::ADDR_PRESCALE);
    wire wr_trim = bus.wr && (bus.addr == csp_pkg::ADDR_TRIM);
    wire rd_ps = bus.rd && (bus.addr == csp_pkg::ADDR_PRESCALE);
    wire rd_trim = bus.rd && (bus.addr == csp_pkg::ADDR_TRIM);
    wire unlock_word = (bus.wdata == csp_pkg::UNLOCK_WORD);
    wire sel_write = wr_ps && unlock_r && !bus.wdata[csp_pkg::UNLOCK_BIT];

    // Unlock window: a repeat unlock neither extends nor clears it
    assign unlock_nxt = unlock_r ? !(sel_write || (unlock_cnt_r == 3'h1)) : (wr_ps && unlock_word); // R21
    assign unlock_cnt_nxt = (!unlock_r && wr_ps && unlock_word) ? csp_pkg::UNLOCK_CYC :
                            (unlock_r ? unlock_cnt_r - 3'h1 : 3'h0); // R21

    // Select resets per the divide-by-eight fuse, caught at release
    wire [3:0] ps_init = fuses.div8 ? csp_pkg::PS_RESET_DIV8 : csp_pkg::PS_RESET_DIV1; // R23
    assign ps_sel_nxt = latch_cyc ? ps_init : (sel_write ? bus.wdata[3:0] : ps_sel_r); // R21 R22

    // Factory value is loaded in the release cycle, before software can write
    assign trim_nxt = latch_cyc ? factory_trim : (wr_trim ? bus.wdata : trim_r); // R15 R16

    // Reserved prescale bits read as zero; unmapped addresses read as zero
    wire [7:0] ps_read = {unlock_r, 3'b000, ps_sel_r};
    assign rdata_nxt = rd_ps ? ps_read : (rd_trim ? trim_r : 8'h00); // R16

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            unlock_r <= 1'b0;
            unlock_cnt_r <= 3'h0;
            ps_sel_r <= csp_pkg::PS_RESET_DIV1;
            trim_r <= csp_pkg::TRIM_RESET;
            rdata_r <= 8'h00;
        end else begin
            unlock_r <= unlock_nxt;
            unlock_cnt_r <= unlock_cnt_nxt;
            ps_sel_r <= ps_sel_nxt;
            trim_r <= trim_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // System clock is gated by the start-up sequencer
    wire run_nxt = (state_nxt == csp_pkg::ST_RUN); // R25

    csp_divider #(
        .SEL_W(csp_pkg::PS_SEL_W),
        .CNT_W(csp_pkg::PS_CNT_W)
    ) u_div (
        .clk(clk),
        .nrst(nrst),
        .run(run_r),
        .sel(ps_sel_r),
        .tick(div_tick),
        .clk_lvl(div_lvl)
    ); // R08 R10

    // The amplifier output pin cannot carry the clock in crystal mode
    wire cko_en = fuse_r.clkout && !is_xtal && run_r; // R12 R13
    wire cko_val = cko_en ? div_lvl : port_out; // R14
    wire cko_oe_val = cko_en || (port_oe && !(fuse_r.clkout && !is_xtal));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_r <= 1'b0;
            cko_r <= 1'b0;
            cko_oe_r <= 1'b0;
            xtal_r <= 1'b0;
            band_r <= 2'b00;
        end else begin
            run_r <= run_nxt;
            cko_r <= cko_val;
            cko_oe_r <= cko_oe_val; // R13
            xtal_r <= is_xtal;
            band_r <= band; // R01
        end
    end

    // Trim is passed whole to the oscillator: bit 7 range, bits 6:0 monotonic tune
    assign trim_value = trim_r; // R17 R18
    assign rdata = rdata_r;
    assign sys_clk = div_lvl;
    assign sys_tick = div_tick;
    assign core_run = run_r;
    assign clock_out_pin_o = cko_r;
    assign clock_out_pin_oe = cko_oe_r;
    assign xtal_mode = xtal_r;
    assign osc_band = band_r;
endmodule

// ---- csp_monitor.sv ----
// Assertion checker for the clock source, prescale and trim block
`timescale 1ns/1ns
module csp_monitor #(
    parameter int CYC_4MS_P = csp_pkg::CYC_4MS,
    parameter int CYC_64MS_P = csp_pkg::CYC_64MS,
    parameter int CYC_16K_P = csp_pkg::CYC_PD_16K
) (
    input wire logic clk,
    input wire logic nrst,
    input wire csp_pkg::csp_fuse_s fuses,
    input wire logic [7:0] factory_trim,
    input wire csp_pkg::csp_bus_s bus,
    input wire logic powerdown_req,
    input wire logic port_out,
    input wire logic port_oe,
    input wire logic [7:0] rdata,
    input wire logic sys_clk,
    input wire logic sys_tick,
    input wire logic core_run,
    input wire logic clock_out_pin_o,
    input wire logic clock_out_pin_oe,
    input wire logic xtal_mode,
    input wire logic [1:0] osc_band,
    input wire logic [7:0] trim_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire trim_wr = bus.wr && bus.addr == csp_pkg::ADDR_TRIM;
    wire trim_rd = bus.rd && bus.addr == csp_pkg::ADDR_TRIM;
    wire ps_rd = bus.rd && bus.addr == csp_pkg::ADDR_PRESCALE;

    rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside read answer");
    trim_write_a: assert property (trim_wr |=> trim_value == $past(bus.wdata))
        else $error("trim write not applied");
    trim_read_a: assert property (trim_rd |=> rdata == $past(trim_value))
        else $error("trim read mismatch");
    ps_reserved_a: assert property (ps_rd |=> rdata[6:4] == 3'h0)
        else $error("reserved prescale bits not zero");
    band_decode_a: assert property ($rose(core_run)
        |-> xtal_mode == fuses.clock_source_select_fuses[3] && osc_band == fuses.clock_source_select_fuses[2:1])
        else $error("oscillator band decode wrong");
    fuse_hold_a: assert property ($past(core_run) && core_run |-> $stable(xtal_mode) && $stable(osc_band))
        else $error("fuse decode changed at run time");
    clk_out_a: assert property ($past(core_run) && core_run && fuses.clkout && !xtal_mode
        |-> clock_out_pin_oe && clock_out_pin_o == $past(sys_clk))
        else $error("clock output pin not following system clock");
    pin_pass_a: assert property (core_run && !fuses.clkout
        |-> clock_out_pin_oe == $past(port_oe) && clock_out_pin_o == $past(port_out))
        else $error("pin normal function lost");
    reset_quiet_a: assert property ($rose(nrst) |-> !clock_out_pin_oe && !clock_out_pin_o)
        else $error("clock driven out during reset");
    pd_stop_a: assert property (core_run && powerdown_req |=> !core_run)
        else $error("core clock not stopped for power-down");

    cover property (trim_wr);
    cover property ($fell(core_run));
    cover property (clock_out_pin_oe && clock_out_pin_o);
endmodule

bind csp_top csp_monitor #(.CYC_4MS_P(CYC_4MS_P), .CYC_64MS_P(CYC_64MS_P), .CYC_16K_P(CYC_16K_P)) u_mon (
    .clk(clk), .nrst(nrst), .fuses(fuses), .factory_trim(factory_trim), .bus(bus),
    .powerdown_req(powerdown_req), .port_out(port_out), .port_oe(port_oe), .rdata(rdata),
    .sys_clk(sys_clk), .sys_tick(sys_tick), .core_run(core_run), .clock_out_pin_o(clock_out_pin_o),
    .clock_out_pin_oe(clock_out_pin_oe), .xtal_mode(xtal_mode), .osc_band(osc_band), .trim_value(trim_value));

// ---- csp_board_model.sv ----
// Board side: the resonator or crystal fitted, and the fuse set programmed to suit it
`timescale 1ns/1ns
module csp_board_model (
    input wire logic quartz,
    input wire csp_pkg::csp_fuse_s want,
    output csp_pkg::csp_fuse_s fuses
);
    // A quartz part is never run on the lowest band, so it is moved one band up
    wire low_band_bad = quartz && want.clock_source_select_fuses[3:1] == csp_pkg::BAND_0P4_0P9;
    assign fuses = low_band_bad ? {csp_pkg::BAND_0P9_3P0, want.clock_source_select_fuses[0], want.startup_time_fuses, want.div8, want.clkout} : want;
endmodule

// ---- csp_top_tb_top.sv ----
// Self-checking testbench for the clock source, prescale and trim block
`timescale 1ns/1ns
module csp_top_tb_top;
    localparam int P4 = 20;
    localparam int P64 = 40;
    localparam int P16 = 30;
    logic clk = 1'b0;
    logic nrst = 1'b1;
    logic quartz, powerdown_req, port_out, port_oe, sys_clk, sys_tick, core_run;
    logic clock_out_pin_o, clock_out_pin_oe, xtal_mode;
    logic [1:0] osc_band;
    logic [7:0] factory_trim, rdata, trim_value;
    csp_pkg::csp_fuse_s want, fuses;
    csp_pkg::csp_bus_s bus;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;

    csp_board_model u_board (.quartz(quartz), .want(want), .fuses(fuses));
    csp_top #(.CYC_4MS_P(P4), .CYC_64MS_P(P64), .CYC_16K_P(P16)) dut (
        .clk(clk), .nrst(nrst), .fuses(fuses), .factory_trim(factory_trim), .bus(bus),
        .powerdown_req(powerdown_req), .port_out(port_out), .port_oe(port_oe), .rdata(rdata),
        .sys_clk(sys_clk), .sys_tick(sys_tick), .core_run(core_run), .clock_out_pin_o(clock_out_pin_o),
        .clock_out_pin_oe(clock_out_pin_oe), .xtal_mode(xtal_mode), .osc_band(osc_band), .trim_value(trim_value));

    always #5 clk = ~clk;
    always @(posedge clk) port_out <= ~port_out;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk("read_data", rdata, exp);
    endtask

    // Expected settle counts follow the shortened 4 ms, 64 ms and 16K parameters
    function automatic int rst_dly(input logic [2:0] k);
        case (k)
            3'h2, 3'h5: return 14;
            3'h0, 3'h3, 3'h6: return 14 + P4;
            default: return 14 + P64;
        endcase
    endfunction

    function automatic int fac(input logic [3:0] code);
        return 1 << (code > 4'h8 ? 8 : int'(code));
    endfunction

    task automatic wait_run(input int n);
        int c;
        c = 0;
        while (core_run !== 1'b1 && c < 2000) begin
            @(posedge clk);
            #1;
            c++;
        end
        chk("run_delay", c >= n && c <= n + 3, 1'b1);
    endtask

    task automatic boot(input csp_pkg::csp_fuse_s f, input logic q, input logic [7:0] ft, input int n);
        @(posedge clk);
        nrst <= 1'b0;
        want <= f;
        quartz <= q;
        factory_trim <= ft;
        @(posedge clk);
        #1 chk("pin_in_reset", {clock_out_pin_oe, clock_out_pin_o}, 2'b00);
        @(posedge clk);
        nrst <= 1'b1;
        wait_run(n);
        chk("trim_load", trim_value, ft);
    endtask

    task automatic wake(input int n);
        @(posedge clk);
        powerdown_req <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("pd_stop", core_run, 1'b0);
        @(posedge clk);
        powerdown_req <= 1'b0;
        wait_run(n);
    endtask

    task automatic next_tick(inout int c);
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (sys_tick !== 1'b1 && c < 3000);
    endtask

    task automatic set_div(input logic [3:0] old_c, input logic [3:0] code);
        int c;
        int c1;
        c = 0;
        wr(csp_pkg::ADDR_PRESCALE, csp_pkg::UNLOCK_WORD);
        wr(csp_pkg::ADDR_PRESCALE, {4'h0, code});
        next_tick(c);
        c1 = c;
        next_tick(c);
        chk("switch_time", c <= fac(old_c) + 2 * fac(code) + 1, 1'b1);
        chk("no_glitch", c - c1 >= (fac(old_c) < fac(code) ? fac(old_c) : fac(code)), 1'b1);
        c1 = c;
        next_tick(c);
        chk("new_period", 16'(c - c1), 16'(fac(code)));
        chk("sys_clk_high", sys_clk, 1'b1);
        rchk(csp_pkg::ADDR_PRESCALE, {4'h0, code});
    endtask

    initial begin
        logic [7:0] tv [3] = '{8'h7f, 8'h80, 8'h7f};
        nrst <= 1'b0;
        bus = '0;
        want = '0;
        quartz = 1'b0;
        powerdown_req = 1'b0;
        port_out = 1'b0;
        port_oe = 1'b1;
        factory_trim = 8'h00;
        boot('{clock_source_select_fuses: csp_pkg::CLOCK_SOURCE_SELECT_FUSES_RC8, startup_time_fuses: csp_pkg::SUT_SHIPPED, div8: 1'b1, clkout: 1'b1}, 1'b0, 8'h70, 54);
        rchk(csp_pkg::ADDR_PRESCALE, csp_pkg::PS_RESET_DIV8);
        wr(6'h10, 8'hff);
        rchk(6'h10, 8'h00);
        // Small trim steps keep the oscillator from jumping
        foreach (tv[k]) begin
            wr(csp_pkg::ADDR_TRIM, tv[k]);
            rchk(csp_pkg::ADDR_TRIM, tv[k]);
        end
        wr(csp_pkg::ADDR_PRESCALE, 8'h05);
        rchk(csp_pkg::ADDR_PRESCALE, 8'h03);
        wr(csp_pkg::ADDR_PRESCALE, 8'h81);
        wr(csp_pkg::ADDR_PRESCALE, 8'h05);
        rchk(csp_pkg::ADDR_PRESCALE, 8'h03);
        wr(csp_pkg::ADDR_PRESCALE, csp_pkg::UNLOCK_WORD);
        rchk(csp_pkg::ADDR_PRESCALE, 8'h83);
        repeat (4) @(posedge clk);
        wr(csp_pkg::ADDR_PRESCALE, 8'h05);
        rchk(csp_pkg::ADDR_PRESCALE, 8'h03);
        for (int k = 0; k <= 9; k++) begin
            set_div(k == 0 ? 4'h3 : 4'(k - 1), 4'(k));
        end
        set_div(4'h9, 4'h2);
        wake(csp_pkg::CYC_PD_RC);
        for (int i = 0; i < 8; i++) begin
            boot('{clock_source_select_fuses: {1'b1, 2'(i), i[2]}, startup_time_fuses: 2'(i), div8: 1'b0, clkout: 1'b0}, i[2], 8'(8'h40 + i),
                rst_dly(3'(i)));
            chk("xtal_mode", xtal_mode, 1'b1);
            chk("osc_band", osc_band, (i == 4) ? 2'h1 : 2'(i));
            rchk(csp_pkg::ADDR_PRESCALE, csp_pkg::PS_RESET_DIV1);
            @(posedge clk);
            want.clock_source_select_fuses <= csp_pkg::CLOCK_SOURCE_SELECT_FUSES_RC8;
            repeat (3) @(posedge clk);
            #1 chk("fuse_hold", {xtal_mode, osc_band}, {1'b1, (i == 4) ? 2'h1 : 2'(i)});
            @(posedge clk);
            want.clock_source_select_fuses <= {1'b1, 2'(i), i[2]};
            wake(i < 2 ? csp_pkg::CYC_PD_258 : (i < 5 ? csp_pkg::CYC_PD_1K : P16));
        end
        close_out();
    end
endmodule
